// ===== hdl/tbcj_carrier_collision_jabber.v
// Purpose: 10 Mb/s carrier sense, collision, jabber, heartbeat and polarity logic
// Assumes: all inputs synchronous to sys_clk; receiving/transmitting come from
//          the PHY datapath; link pulse polarity is sampled by the receiver
// Notes:   long intervals are parameters so a simulation can shorten them
`timescale 1ns/10ps
`include "tbcj_defines.vh"

// Behaviour
// RULE1: half duplex: carrier sense while transmitting or receiving.
// RULE2: full duplex or repeater: carrier sense only while receiving.
// RULE3: half duplex: collision while receive overlaps transmit.
// RULE4: full duplex: collision always low.
// RULE5: jabber trips when one transmission exceeds about 21 ms.
// RULE6: jabber trip raises collision and blocks transmit for about 324 ms.
// RULE7: link pulses continue during deactivation; sticky jabber flag set.
// RULE8: jabber inhibit defaults zero; one disables the watchdog completely.
// RULE9: heartbeat: after transmit enable falls, wait about 630 ns, pulse collision.
// RULE10: heartbeat delay within ten plus or minus five bit times.
// RULE11: heartbeat pulse lasts about 1 us, between 0.6 and 1.6 us.
// RULE12: heartbeat only in node, half duplex, link valid, inhibit zero.
// RULE13: heartbeat suppressed in repeater, full duplex, link fail or inhibit.
// RULE14: with polarity inhibit zero, detect reversed link pulses and invert data.
// RULE15: reversed polarity corrected sets sticky polarity flag.
// RULE16: polarity correction also active during 100 Mb/s auto-negotiation.
// RULE17: link pulses every 16 ms when idle or in jabber deactivation.
// RULE18: link fails after about 82 ms without data or pulses; stops heartbeat.
// RULE19: sticky flags clear only on reset or a read after condition ends.
// RULE20: jabber collision spans whole deactivation; data resumes afterwards.
module tbcj_carrier_collision_jabber #(
  parameter integer JAB_LIMIT_CYC  = `TBCJ_JAB_LIMIT_CYC,
  parameter integer JAB_DEACT_CYC  = `TBCJ_JAB_DEACT_CYC,
  parameter integer LINK_PULSE_CYC = `TBCJ_LINK_PULSE_CYC,
  parameter integer LINK_FAIL_CYC  = `TBCJ_LINK_FAIL_CYC,
  parameter integer SQE_DELAY_CYC  = `TBCJ_SQE_DELAY_CYC,
  parameter integer SQE_WIDTH_CYC  = `TBCJ_SQE_WIDTH_CYC
) (
  // clock and reset
  input  wire sys_clk,
  input  wire rst,
  // mode
  input  wire full_duplex,
  input  wire repeater_mode,
  input  wire mode_10m,
  input  wire autoneg_active,
  // management controls
  input  wire jabber_inhibit,
  input  wire sqe_inhibit,
  input  wire polarity_inhibit,
  input  wire jabber_flag_rd,
  input  wire polarity_flag_rd,
  // mac side
  input  wire tx_en,
  input  wire tx_data,
  // line side, receive
  input  wire rx_active,
  input  wire rx_data_raw,
  input  wire nlp_seen,
  input  wire nlp_negative,
  // line side, transmit
  output reg  line_tx_data_q,
  output reg  line_tx_active_q,
  output reg  link_pulse_q,
  // mac side outputs
  output reg  crs_q,
  output reg  col_q,
  output reg  rx_data_q,
  // status
  output wire link_valid,
  output reg  jabber_active_q,
  output wire jabber_flag,
  output wire polarity_flag
);

  // --------------------------------------------------------------------------
  // local state
  // --------------------------------------------------------------------------
  localparam [2:0] SQE_IDLE  = 3'b001;
  localparam [2:0] SQE_WAIT  = 3'b010;
  localparam [2:0] SQE_PULSE = 3'b100;

  reg  [2:0]  sqe_state_q;
  reg  [2:0]  sqe_state_d;
  reg  [31:0] sqe_cnt_q;
  reg  [31:0] sqe_cnt_d;
  reg         tx_en_q;
  reg  [31:0] jab_cnt_q;
  reg  [31:0] pulse_cnt_q;
  reg  [31:0] fail_cnt_q;
  reg         link_valid_q;
  reg         pol_invert_q;
  wire        jab_trip;
  wire        deact_busy;
  wire        deact_done;
  wire        transmitting;
  wire        sqe_allowed;
  wire        pol_reversed_evt;

  // saturating increment used by the jabber length and link-fail counters
  function [31:0] tbcj_inc;
    input [31:0] val;
    begin
      tbcj_inc = (val == 32'hFFFF_FFFF) ? val : val + 32'h0000_0001;
    end
  endfunction

  // --------------------------------------------------------------------------
  // jabber watchdog
  // --------------------------------------------------------------------------
  // transmitting means the line is actually carrying our data
  assign transmitting = tx_en && !jabber_active_q;

  // RULE5 transmission length timer; counts only while tx enable holds
  always @(posedge sys_clk) begin
    if (rst) begin
      jab_cnt_q <= 32'h0000_0000;
    end else if (!tx_en || jabber_inhibit || jabber_active_q) begin
      jab_cnt_q <= 32'h0000_0000;
    end else begin
      jab_cnt_q <= tbcj_inc(jab_cnt_q);
    end
  end

  // RULE8 inhibit gates the trip; default zero keeps the watchdog armed
  assign jab_trip = tx_en && !jabber_inhibit && !jabber_active_q &&
                    (jab_cnt_q >= JAB_LIMIT_CYC);

  // RULE6 deactivation interval timer
  tbcj_interval_timer #(
    .WIDTH (32)
  ) u_deact (
    .sys_clk (sys_clk),
    .rst     (rst),
    .load    (jab_trip),
    .run     (!jabber_inhibit),
    .count   (JAB_DEACT_CYC),
    .busy_q  (deact_busy),
    .done_q  (deact_done)
  );

  // RULE20 held through the whole interval, released at its end
  always @(posedge sys_clk) begin
    if (rst) begin
      jabber_active_q <= 1'b0;
    end else if (jab_trip) begin
      jabber_active_q <= 1'b1;
    end else if (deact_done || jabber_inhibit || !deact_busy) begin
      jabber_active_q <= 1'b0;
    end
  end

  // RULE7 sticky jabber flag
  // RULE19 read clears only after deactivation ends
  tbcj_sticky_set_flag u_jab_flag (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .set_evt  (jab_trip),
    .cond_now (jabber_active_q),
    .rd_stb   (jabber_flag_rd),
    .flag_q   (jabber_flag)
  );

  // --------------------------------------------------------------------------
  // transmit path and link pulses
  // --------------------------------------------------------------------------
  // RULE6 data blocked from the line during deactivation
  always @(posedge sys_clk) begin
    if (rst) begin
      line_tx_data_q   <= 1'b0;
      line_tx_active_q <= 1'b0;
    end else begin
      line_tx_active_q <= transmitting;
      line_tx_data_q   <= transmitting ? tx_data : 1'b0;
    end
  end

  // RULE17 periodic link pulse while not sending data
  // RULE7 pulses carry on during jabber deactivation
  always @(posedge sys_clk) begin
    if (rst) begin
      pulse_cnt_q  <= 32'h0000_0000;
      link_pulse_q <= 1'b0;
    end else if (transmitting) begin
      pulse_cnt_q  <= 32'h0000_0000;
      link_pulse_q <= 1'b0;
    end else if (pulse_cnt_q >= LINK_PULSE_CYC - 1) begin
      pulse_cnt_q  <= 32'h0000_0000;
      link_pulse_q <= 1'b1;
    end else begin
      pulse_cnt_q  <= pulse_cnt_q + 32'h0000_0001;
      link_pulse_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // link monitor
  // --------------------------------------------------------------------------
  // RULE18 silence timer; any data or link pulse restarts it
  always @(posedge sys_clk) begin
    if (rst) begin
      fail_cnt_q   <= 32'h0000_0000;
      link_valid_q <= 1'b0;
    end else if (rx_active || nlp_seen) begin
      fail_cnt_q   <= 32'h0000_0000;
      link_valid_q <= 1'b1;
    end else if (fail_cnt_q >= LINK_FAIL_CYC) begin
      link_valid_q <= 1'b0;
    end else begin
      fail_cnt_q <= tbcj_inc(fail_cnt_q);
    end
  end

  assign link_valid = link_valid_q;

  // --------------------------------------------------------------------------
  // receive polarity correction
  // --------------------------------------------------------------------------
  // RULE14 reversed pulse seen with correction enabled
  // RULE16 also runs during auto-negotiation, not only in 10 Mb/s mode
  assign pol_reversed_evt = nlp_seen && nlp_negative && !polarity_inhibit &&
                            (mode_10m || autoneg_active);

  // latest pulse polarity decides; inhibit restores straight wiring
  always @(posedge sys_clk) begin
    if (rst) begin
      pol_invert_q <= `TBCJ_POL_RST;
    end else if (polarity_inhibit) begin
      pol_invert_q <= 1'b0;
    end else if (nlp_seen && (mode_10m || autoneg_active)) begin
      pol_invert_q <= nlp_negative;
    end
  end

  // RULE14 corrected receive data
  always @(posedge sys_clk) begin
    if (rst) begin
      rx_data_q <= 1'b0;
    end else begin
      rx_data_q <= rx_data_raw ^ pol_invert_q;
    end
  end

  // RULE15 sticky polarity flag
  // RULE19 read clears only once polarity is straight again
  tbcj_sticky_set_flag u_pol_flag (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .set_evt  (pol_reversed_evt),
    .cond_now (pol_invert_q),
    .rd_stb   (polarity_flag_rd),
    .flag_q   (polarity_flag)
  );

  // --------------------------------------------------------------------------
  // heartbeat test
  // --------------------------------------------------------------------------
  // RULE12 all enabling conditions together
  // RULE13 repeater, full duplex, link fail or inhibit suppress it
  assign sqe_allowed = !repeater_mode && !full_duplex && link_valid_q && !sqe_inhibit;

  // edge detect on transmit enable
  always @(posedge sys_clk) begin
    if (rst) begin
      tx_en_q <= 1'b0;
    end else begin
      tx_en_q <= tx_en;
    end
  end

  // RULE9 falling edge starts the delay, then the pulse
  always @* begin
    sqe_state_d = sqe_state_q;
    sqe_cnt_d   = sqe_cnt_q;
    case (sqe_state_q)
      SQE_IDLE: begin
        if (tx_en_q && !tx_en && sqe_allowed) begin
          sqe_state_d = SQE_WAIT;
          sqe_cnt_d   = 32'h0000_0000;
        end
      end
      SQE_WAIT: begin
        // RULE10 630 ns sits inside the five to fifteen bit window
        if (sqe_cnt_q >= SQE_DELAY_CYC - 1) begin
          sqe_state_d = SQE_PULSE;
          sqe_cnt_d   = 32'h0000_0000;
        end else begin
          sqe_cnt_d = sqe_cnt_q + 32'h0000_0001;
        end
      end
      SQE_PULSE: begin
        // RULE11 pulse width of one microsecond
        if (sqe_cnt_q >= SQE_WIDTH_CYC - 1) begin
          sqe_state_d = SQE_IDLE;
          sqe_cnt_d   = 32'h0000_0000;
        end else begin
          sqe_cnt_d = sqe_cnt_q + 32'h0000_0001;
        end
      end
      default: begin
        sqe_state_d = SQE_IDLE;
        sqe_cnt_d   = 32'h0000_0000;
      end
    endcase
    // a new frame or loss of enable aborts the test
    if (tx_en || !sqe_allowed) begin
      sqe_state_d = SQE_IDLE;
      sqe_cnt_d   = 32'h0000_0000;
    end
  end

  // heartbeat state register
  always @(posedge sys_clk) begin
    if (rst) begin
      sqe_state_q <= SQE_IDLE;
      sqe_cnt_q   <= 32'h0000_0000;
    end else begin
      sqe_state_q <= sqe_state_d;
      sqe_cnt_q   <= sqe_cnt_d;
    end
  end

  // --------------------------------------------------------------------------
  // carrier sense and collision toward the mac
  // --------------------------------------------------------------------------
  // registered so the mac sees clean levels
  always @(posedge sys_clk) begin
    if (rst) begin
      crs_q <= 1'b0;
      col_q <= 1'b0;
    end else begin
      if (full_duplex || repeater_mode) begin
        // RULE2 receive only
        crs_q <= rx_active;
      end else begin
        // RULE1 transmit or receive
        crs_q <= rx_active || tx_en;
      end
      if (full_duplex) begin
        // RULE4 never in full duplex
        col_q <= 1'b0;
      end else begin
        // RULE3 overlap, RULE6 jabber, RULE9 heartbeat
        col_q <= (rx_active && transmitting) || jabber_active_q ||
                 (sqe_state_q == SQE_PULSE);
      end
    end
  end

endmodule

// ===== hdl/tbcj_defines.vh
// Purpose: shared constants of the 10 Mb/s carrier, collision and jabber block
// Assumes: sys_clk runs at 50 MHz (20 ns period)
// Notes:   times are kept in their own units, cycle counts are derived from them
`ifndef TBCJ_DEFINES_VH
`define TBCJ_DEFINES_VH

// ----------------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------------
`define TBCJ_CLK_NS          20

// ----------------------------------------------------------------------------
// timing figures
// ----------------------------------------------------------------------------
`define TBCJ_JAB_LIMIT_MS    21
`define TBCJ_JAB_DEACT_MS    324
`define TBCJ_LINK_PULSE_MS   16
`define TBCJ_LINK_FAIL_MS    82
`define TBCJ_SQE_DELAY_NS    630
`define TBCJ_SQE_WIDTH_NS    1000

// derived cycle counts (delay and width are least/typical figures, rounded up)
`define TBCJ_JAB_LIMIT_CYC   ((`TBCJ_JAB_LIMIT_MS * 1000000) / `TBCJ_CLK_NS)
`define TBCJ_JAB_DEACT_CYC   ((`TBCJ_JAB_DEACT_MS * 1000000) / `TBCJ_CLK_NS)
`define TBCJ_LINK_PULSE_CYC  ((`TBCJ_LINK_PULSE_MS * 1000000) / `TBCJ_CLK_NS)
`define TBCJ_LINK_FAIL_CYC   ((`TBCJ_LINK_FAIL_MS * 1000000) / `TBCJ_CLK_NS)
`define TBCJ_SQE_DELAY_CYC   ((`TBCJ_SQE_DELAY_NS + `TBCJ_CLK_NS - 1) / `TBCJ_CLK_NS)
`define TBCJ_SQE_WIDTH_CYC   ((`TBCJ_SQE_WIDTH_NS + `TBCJ_CLK_NS - 1) / `TBCJ_CLK_NS)

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define TBCJ_FLAG_RST        1'b0
`define TBCJ_POL_RST         1'b0

`endif

// ===== hdl/tbcj_sticky_set_flag.v
// Purpose: sticky status flag, set by an event, cleared by a read
// Assumes: read strobe is a one-cycle pulse
// Notes:   set wins over a clearing read in the same cycle
`timescale 1ns/10ps
`include "tbcj_defines.vh"

module tbcj_sticky_set_flag (
  // clock and reset
  input  wire sys_clk,
  input  wire rst,
  // event and access
  input  wire set_evt,
  input  wire cond_now,
  input  wire rd_stb,
  // flag
  output reg  flag_q
);

  // clear only once the condition has gone away, never in the set cycle
  always @(posedge sys_clk) begin
    if (rst) begin
      flag_q <= `TBCJ_FLAG_RST;
    end else if (set_evt) begin
      flag_q <= 1'b1;
    end else if (rd_stb && !cond_now) begin
      flag_q <= 1'b0;
    end
  end

endmodule

// ===== hdl/tbcj_interval_timer.v
// Purpose: loadable down counter that reports when an interval has run out
// Assumes: start and stop are levels sampled each clock
// Notes:   done is a one-cycle pulse on expiry
`timescale 1ns/10ps

module tbcj_interval_timer #(
  parameter integer WIDTH = 32
) (
  // clock and reset
  input  wire             sys_clk,
  input  wire             rst,
  // control
  input  wire             load,
  input  wire             run,
  input  wire [WIDTH-1:0] count,
  // status
  output reg              busy_q,
  output reg              done_q
);

  reg [WIDTH-1:0] cnt_q;

  // load restarts, run lets it count, dropping run abandons the interval
  always @(posedge sys_clk) begin
    if (rst) begin
      cnt_q  <= {WIDTH{1'b0}};
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (load) begin
        cnt_q  <= count;
        busy_q <= 1'b1;
      end else if (!run) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        if (cnt_q <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// ===== testbench/tbcj_ccj_properties.sv
// Purpose: port-level checks of carrier, collision, jabber and heartbeat
// Assumes: one clock, synchronous active-high reset
// Notes:   windows follow the one-cycle output latency of the block
`timescale 1ns/10ps

module tbcj_ccj_properties #(
  parameter integer LINK_PULSE_CYC = 50
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // modes and controls
  input wire full_duplex,
  input wire repeater_mode,
  input wire mode_10m,
  input wire autoneg_active,
  input wire jabber_inhibit,
  input wire sqe_inhibit,
  input wire polarity_inhibit,
  // activity
  input wire tx_en,
  input wire rx_active,
  input wire nlp_seen,
  input wire nlp_negative,
  // outputs watched
  input wire line_tx_active_q,
  input wire link_pulse_q,
  input wire crs_q,
  input wire col_q,
  input wire link_valid,
  input wire jabber_active_q,
  input wire jabber_flag,
  input wire polarity_flag
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  integer gap_q;
  // cycles since the last link pulse; restarted by line activity
  always @(posedge sys_clk) begin
    if (rst || link_pulse_q || line_tx_active_q) gap_q <= 0;
    else gap_q <= gap_q + 1;
  end
  sequence sqe_fall;
    $past(!rst) && !full_duplex && !repeater_mode && !sqe_inhibit && link_valid
      && $fell(tx_en) && !col_q && !jabber_active_q;
  endsequence
  sequence sqe_off_fall;
    $fell(tx_en) && (full_duplex || repeater_mode || sqe_inhibit || !link_valid);
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_crs_half_duplex: assert property (($past(!rst && !full_duplex && !repeater_mode))
    |-> crs_q == $past(tx_en || rx_active)) else $error("carrier wrong in half duplex");
  chk_crs_rx_only: assert property ($past(!rst && (full_duplex || repeater_mode))
    |-> crs_q == $past(rx_active)) else $error("carrier follows own transmit");
  chk_col_overlap: assert property ($past(!rst && !full_duplex && !repeater_mode
    && tx_en && rx_active) |-> col_q) else $error("no collision on overlap");
  chk_col_fdx_low: assert property ($past(!rst && full_duplex) && full_duplex
    |-> !col_q) else $error("collision in full duplex");
  chk_jab_col_block: assert property ($past(jabber_active_q) && jabber_active_q
    |-> (col_q || $past(full_duplex)) && !line_tx_active_q) else $error("jabber not blocking");
  chk_jab_flag_set: assert property ($rose(jabber_active_q) |-> jabber_flag)
    else $error("jabber flag not set");
  chk_jab_inhibit_off: assert property ($past(jabber_inhibit)
    |-> !$rose(jabber_active_q)) else $error("jabber while inhibited");
  chk_sqe_pulse_shape: assert property (sqe_fall |-> ##[25:75] $rose(col_q)
    ##29 col_q ##[1:51] !col_q) else $error("heartbeat timing wrong");
  chk_sqe_suppressed: assert property (sqe_off_fall
    |-> not (##[1:80] $rose(col_q))) else $error("heartbeat not suppressed");
  chk_nlp_gap_bound: assert property (gap_q <= LINK_PULSE_CYC + 3)
    else $error("link pulse missing");
  chk_pol_flag_set: assert property (nlp_seen && nlp_negative && !polarity_inhibit
    && (mode_10m || autoneg_active) |-> ##[1:2] polarity_flag) else $error("polarity flag not set");
endmodule

bind tbcj_carrier_collision_jabber tbcj_ccj_properties #(.LINK_PULSE_CYC(LINK_PULSE_CYC))
  chk_inst (.sys_clk(sys_clk), .rst(rst), .full_duplex(full_duplex),
  .repeater_mode(repeater_mode), .jabber_inhibit(jabber_inhibit),
  .mode_10m(mode_10m), .autoneg_active(autoneg_active),
  .sqe_inhibit(sqe_inhibit), .polarity_inhibit(polarity_inhibit), .tx_en(tx_en),
  .rx_active(rx_active), .nlp_seen(nlp_seen), .nlp_negative(nlp_negative),
  .line_tx_active_q(line_tx_active_q), .link_pulse_q(link_pulse_q), .crs_q(crs_q),
  .col_q(col_q), .link_valid(link_valid), .jabber_active_q(jabber_active_q),
  .jabber_flag(jabber_flag), .polarity_flag(polarity_flag));

// ===== testbench/tbcj_mac_model.sv
// Purpose: serial MAC transmitter sending one frame per request
// Assumes: request is a one-cycle pulse, len counted in cycles
// Notes:   data toggles every cycle so idle bits never repeat the last one
`timescale 1ns/10ps

module tbcj_mac_model (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // frame request
  input  wire        go,
  input  wire [15:0] len,
  // mac transmit
  output reg         tx_en   = 1'h0,
  output reg         tx_data = 1'h0
);
  reg [15:0] left_q = 16'h0000;
  // frame timer; a request during a frame is ignored
  always @(posedge sys_clk) begin
    tx_data <= rst ? 1'h0 : ~tx_data;
    if (rst) begin
      tx_en <= 1'h0;
    end else if (go && !tx_en) begin
      tx_en  <= 1'h1;
      left_q <= len;
    end else if (tx_en) begin
      left_q <= left_q - 16'h0001;
      if (left_q == 16'h0001) tx_en <= 1'h0;
    end
  end
endmodule

// ===== testbench/tb.sv
// Purpose: self-checking bench for carrier, collision, jabber, heartbeat, polarity
// Assumes: long intervals shortened through the block's parameters
// Notes:   all stimulus lands 1 ns after a rising edge
`timescale 1ns/10ps
`include "tbcj_defines.vh"

module tb;
  localparam integer JL = 100;
  localparam integer JD = 500;
  localparam integer LP = 50;
  localparam integer LF = 300;
  reg sys_clk = 1'h0, rst = 1'h1, go = 1'h0;
  reg full_duplex = 1'h0, repeater_mode = 1'h0, mode_10m = 1'h1, autoneg_active = 1'h0;
  reg jabber_inhibit = 1'h0, sqe_inhibit = 1'h0, polarity_inhibit = 1'h0;
  reg jabber_flag_rd = 1'h0, polarity_flag_rd = 1'h0, rx_active = 1'h0;
  reg rx_data_raw = 1'h0, nlp_seen = 1'h0, nlp_negative = 1'h0;
  reg [15:0] flen = 16'h0000;
  wire tx_en, tx_data, line_tx_data_q, line_tx_active_q, link_pulse_q, crs_q, col_q;
  wire rx_data_q, link_valid, jabber_active_q, jabber_flag, polarity_flag;
  integer n_mismatch = 0, check_count = 0, m, d, w, h;

  always #10 sys_clk = ~sys_clk;

  tbcj_mac_model tbcj_mac_model_inst (.sys_clk(sys_clk), .rst(rst), .go(go), .len(flen),
    .tx_en(tx_en), .tx_data(tx_data));
  tbcj_carrier_collision_jabber #(.JAB_LIMIT_CYC(JL), .JAB_DEACT_CYC(JD),
    .LINK_PULSE_CYC(LP), .LINK_FAIL_CYC(LF)) tbcj_carrier_collision_jabber_inst (
    .sys_clk(sys_clk), .rst(rst), .full_duplex(full_duplex), .repeater_mode(repeater_mode),
    .mode_10m(mode_10m), .autoneg_active(autoneg_active), .jabber_inhibit(jabber_inhibit),
    .sqe_inhibit(sqe_inhibit), .polarity_inhibit(polarity_inhibit),
    .jabber_flag_rd(jabber_flag_rd), .polarity_flag_rd(polarity_flag_rd), .tx_en(tx_en),
    .tx_data(tx_data), .rx_active(rx_active), .rx_data_raw(rx_data_raw),
    .nlp_seen(nlp_seen), .nlp_negative(nlp_negative), .line_tx_data_q(line_tx_data_q),
    .line_tx_active_q(line_tx_active_q), .link_pulse_q(link_pulse_q), .crs_q(crs_q),
    .col_q(col_q), .rx_data_q(rx_data_q), .link_valid(link_valid),
    .jabber_active_q(jabber_active_q), .jabber_flag(jabber_flag),
    .polarity_flag(polarity_flag));

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task cyc(input integer n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task chk(input logic got, input logic exp, input string msg);
    check_count = check_count + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask
  // one frame; returns once the model has raised tx_en
  task send(input integer len);
    go <= 1'h1;
    flen <= len[15:0];
    cyc(1);
    go <= 1'h0;
  endtask
  // bounded wait for the end of the frame
  task wait_tx;
    for (h = 0; h < 1000 && tx_en !== 1'h0; h = h + 1) cyc(1);
  endtask
  task nlp(input logic neg);
    nlp_seen <= 1'h1;
    nlp_negative <= neg;
    cyc(1);
    nlp_seen <= 1'h0;
    cyc(2);
  endtask
  task rd(input logic pol);
    if (pol) polarity_flag_rd <= 1'h1;
    else jabber_flag_rd <= 1'h1;
    cyc(1);
    polarity_flag_rd <= 1'h0;
    jabber_flag_rd <= 1'h0;
    cyc(2);
  endtask
  task conclude;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    cyc(12);
    rst <= 1'h0;
    cyc(1);
    chk(crs_q | col_q | jabber_flag | polarity_flag, 1'h0, "reset outputs");
    rx_active <= 1'h1;
    cyc(2);
    chk(crs_q, 1'h1, "crs on receive");
    rx_active <= 1'h0;
    send(20);
    cyc(2);
    chk(crs_q & line_tx_active_q, 1'h1, "crs on transmit");
    wait_tx;
    cyc(120);
    send(40);
    rx_active <= 1'h1;
    cyc(3);
    chk(col_q, 1'h1, "collision on overlap");
    wait_tx;
    rx_active <= 1'h0;
    cyc(120);
    // full duplex, then repeater: own transmit gives no carrier
    for (m = 0; m < 2; m = m + 1) begin
      full_duplex <= (m == 0);
      repeater_mode <= (m == 1);
      send(40);
      cyc(3);
      chk(crs_q, 1'h0, "crs from own transmit");
      rx_active <= 1'h1;
      cyc(3);
      chk(crs_q, 1'h1, "crs on receive");
      if (m == 0) chk(col_q, 1'h0, "full duplex collision");
      wait_tx;
      rx_active <= 1'h0;
      cyc(120);
    end
    full_duplex <= 1'h0;
    repeater_mode <= 1'h0;
    nlp(1'h0);
    send(20);
    wait_tx;
    for (d = 0; d < 100 && col_q !== 1'h1; d = d + 1) cyc(1);
    for (w = 0; w < 100 && col_q === 1'h1; w = w + 1) cyc(1);
    chk(d >= 25 && d <= 75, 1'h1, "heartbeat delay");
    chk(w == `TBCJ_SQE_WIDTH_CYC, 1'h1, "heartbeat width");
    // heartbeat suppressors: full duplex, repeater, inhibit, failed link
    for (m = 0; m < 4; m = m + 1) begin
      full_duplex <= (m == 0);
      repeater_mode <= (m == 1);
      sqe_inhibit <= (m == 2);
      if (m == 3) cyc(LF + 20);
      else nlp(1'h0);
      if (m == 3) chk(link_valid, 1'h0, "link failed");
      send(20);
      wait_tx;
      w = 0;
      repeat (100) begin
        cyc(1);
        if (col_q !== 1'h0) w = w + 1;
      end
      chk(w == 0, 1'h1, "heartbeat suppressed");
    end
    full_duplex <= 1'h0;
    repeater_mode <= 1'h0;
    sqe_inhibit <= 1'h0;
    // polarity during auto-negotiation
    mode_10m <= 1'h0;
    autoneg_active <= 1'h1;
    rx_data_raw <= 1'h1;
    nlp(1'h1);
    chk(polarity_flag, 1'h1, "polarity flag");
    chk(rx_data_q, 1'h0, "data inverted");
    rd(1'h1);
    chk(polarity_flag, 1'h1, "flag held while reversed");
    nlp(1'h0);
    chk(rx_data_q, 1'h1, "data straight");
    rd(1'h1);
    chk(polarity_flag, 1'h0, "flag cleared");
    polarity_inhibit <= 1'h1;
    nlp(1'h1);
    chk(polarity_flag | ~rx_data_q, 1'h0, "correction inhibited");
    polarity_inhibit <= 1'h0;
    mode_10m <= 1'h1;
    autoneg_active <= 1'h0;
    // jabber trip, deactivation and release
    nlp(1'h0);
    send(250);
    for (d = 0; d < 200 && jabber_active_q !== 1'h1; d = d + 1) cyc(1);
    chk(d >= JL - 5 && d <= JL + 5, 1'h1, "jabber limit");
    cyc(2);
    chk(col_q & ~line_tx_active_q & jabber_flag, 1'h1, "jabber effects");
    rd(1'h0);
    chk(jabber_flag, 1'h1, "jabber flag held");
    w = 0;
    m = 0;
    for (d = 0; d < 1000 && jabber_active_q === 1'h1; d = d + 1) begin
      cyc(1);
      if (link_pulse_q === 1'h1) w = w + 1;
      if (line_tx_data_q !== 1'h0) m = m + 1;
    end
    chk(d >= JD - 12 && d <= JD + 2, 1'h1, "deactivation span");
    chk(m == 0, 1'h1, "line data during jabber");
    chk(w >= JD / LP - 2, 1'h1, "link pulses in jabber");
    rd(1'h0);
    chk(jabber_flag, 1'h0, "jabber flag cleared");
    send(20);
    cyc(2);
    chk(line_tx_active_q, 1'h1, "transmit resumed");
    chk(line_tx_data_q, ~tx_data, "line data resumed");
    wait_tx;
    cyc(120);
    jabber_inhibit <= 1'h1;
    send(250);
    w = 0;
    for (d = 0; d < 400 && tx_en === 1'h1; d = d + 1) begin
      cyc(1);
      if (jabber_active_q !== 1'h0) w = w + 1;
    end
    chk(w == 0, 1'h1, "watchdog inhibited");
    jabber_inhibit <= 1'h0;
    cyc(120);
    conclude;
  end

  // watchdog well beyond the expected few thousand cycles
  initial begin
    #400000;
    n_mismatch = n_mismatch + 1;
    conclude;
  end
endmodule
